// File: common/i2c_ctl_cfg.svh
// Constants of the I2C control and time-out block: offsets, bits, codes, timing.
// Assumes inclusion by bare name from the block's design and testbench files.
`ifndef I2C_CTL_CFG_SVH
`define I2C_CTL_CFG_SVH

// ----------------------------------------
// Register word indices; byte address is four times the index
// ----------------------------------------
`define OFS_CTRL   8'hc0
`define OFS_TOC    8'hc4
`define OFS_ADDR   8'hc1
`define OFS_STAT   8'hcc
`define OFS_DATA   8'hd0
`define OFS_IEN    8'hd4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_SERIAL_ENABLE     6
`define B_STA      5
`define B_STO      4
`define B_SI       3
`define B_AA       2
`define B_TIMEOUT_COUNT_ENABLE     2
`define B_TIMEOUT_PRESCALE_SELECT     1
`define B_TIF      0
`define B_EA       1
`define B_EI       0

// ----------------------------------------
// Counter limits and timing
// ----------------------------------------
`define TO_MAX        14'h3fff
`define PRE_LAST      2'h3
`define CLK_PERIOD_NS 25
`define QTR_TIME_NS   2500

// ----------------------------------------
// Bus state codes
// ----------------------------------------
`define ST_START    8'h08
`define ST_RSTART   8'h10
`define ST_AW_ACK   8'h18
`define ST_AW_NACK  8'h20
`define ST_TX_ACK   8'h28
`define ST_TX_NACK  8'h30
`define ST_AR_ACK   8'h40
`define ST_AR_NACK  8'h48
`define ST_RX_ACK   8'h50
`define ST_RX_NACK  8'h58
`define ST_SLA      8'h60
`define ST_GCALL    8'h70
`define ST_SRX_ACK  8'h80
`define ST_SRX_NACK 8'h88
`define ST_SSTOP    8'ha0
`define ST_NONE     8'hf8

`endif

// File: common/i2c_ctl_pkg.sv
// Types of the I2C control and time-out block: engine states and the state record.
// Assumes the block keeps all of its state in one packed record.
package i2c_ctl_pkg;

    // ----------------------------------------
    // Bus engine states
    // ----------------------------------------
    typedef enum logic [2:0] {
        s_idle  = 3'b000,
        s_wait  = 3'b001,
        s_start = 3'b010,
        s_bit   = 3'b011,
        s_hold  = 3'b100,
        s_stop  = 3'b101,
        s_slv   = 3'b110
    } eng_e;

    // ----------------------------------------
    // Whole block state
    // ----------------------------------------
    typedef struct packed {
        eng_e        eng;
        logic [1:0]  q;
        logic [7:0]  dcnt;
        logic [3:0]  bits;
        logic [7:0]  shreg;
        logic [7:0]  pcode;
        logic        drv;
        logic        serial_enable, begin_condition_request, end_condition_request, si, aa;
        logic        timeout_count_enable, timeout_prescale_select, timeout_flag;
        logic [6:0]  own;
        logic        gc, ea, ei;
        logic [7:0]  data, stat;
        logic [13:0] tcnt;
        logic [1:0]  pre;
        logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
        logic        busy, mst, adr, rd, first, ack;
        logic        scl_oe, sda_oe, irq;
        logic        ahb_pend, ahb_wr, hready;
        logic [7:0]  ahb_a;
        logic [31:0] hrdata;
    } st_s;

endpackage

// File: hdl/i2c_ctl.sv
// I2C serial port control, bus engine and 14-bit bus time-out, AHB-Lite slave.
// Assumes one 40 MHz clock; open-drain lines resolved outside from the enables.
// Functional notes
// R1 - Time-out counter runs only while count enable and serial enable are both set.
// R2 - Setting the serial event flag stops and zeroes the time-out count.
// R3 - Prescale select 0 counts every clock, 1 counts every fourth clock.
// R4 - Overflow sets the time-out flag and requests the interrupt when enabled.
// R5 - Hardware never clears the time-out flag; software writes zero to clear it.
// R6 - Software clears the event flag before enabling the time-out counter.
// R7 - Serial enable low floats lines, ignores the bus, forces end request low.
// R8 - Begin request enters master; start if bus free, else after stop and delay.
// R9 - Begin request after bytes as master sends a repeated start.
// R10 - Begin request is accepted any time, even as an addressed slave.
// R11 - Master end request sends stop; the bit clears when stop is seen.
// R12 - Slave end request returns to the not-addressed slave state.
// R13 - Master with both requests sends stop then start.
// R14 - Slave with both requests does an internal stop, nothing on the bus.
// R15 - New state code sets the event flag; interrupt when both enables set.
// R16 - State code F8 never sets the event flag.
// R17 - Event flag set holds SCL low in its low phase.
// R18 - Only software clears the event flag; clearing releases SCL and request.
// R19 - Ack assert low returns not-acknowledge after received data bytes.
// R20 - Ack assert high acknowledges own address, data, enabled general call.
// R21 - General call address answered only with general call enable set.
// R22 - Software loads the own address; master mode ignores it.
// R23 - Overflow is all ones to zero, flag set on that same edge.
// R24 - No start or repeated start while the begin request is low.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "i2c_ctl_cfg.svh"
module i2c_ctl
    import i2c_ctl_pkg::*;
#(
    parameter int QTR_CYC = `QTR_TIME_NS / `CLK_PERIOD_NS
)(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    output logic             irq_o
);

    localparam logic [7:0] QLAST = 8'(QTR_CYC - 1);

    st_s        r;
    st_s        n;
    logic [7:0] wd;
    logic       start_det, stop_det, tick, adv, scl_rise, scl_fall;
    logic       run, pre_hit, rx, own_hit, gc_hit, toc_wr;

    // Status posting; the no-information code never raises the flag
    function automatic st_s post(input st_s s, input logic [7:0] c);
        post      = s;
        post.stat = c;
        if (c != `ST_NONE) begin
            post.si = 1'b1;
        end
    endfunction

    // ----------------------------------------
    // Decoded conditions
    // ----------------------------------------
    // Edges use the second and third stages only
    assign wd        = hwdata_i[7:0];
    assign start_det = r.serial_enable & r.scl_s & r.scl_d & r.sda_d & ~r.sda_s; // R7
    assign stop_det  = r.serial_enable & r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
    assign scl_rise  = r.serial_enable & r.scl_s & ~r.scl_d;
    assign scl_fall  = r.serial_enable & ~r.scl_s & r.scl_d;
    assign tick      = (r.dcnt == QLAST);
    // A quarter in which SCL was released waits for the line to go high
    assign adv       = tick & ~(r.q == 2'h1 & ~r.scl_s);
    assign run       = r.timeout_count_enable & r.serial_enable & ~r.si;
    assign pre_hit   = ~r.timeout_prescale_select | (r.pre == `PRE_LAST);
    assign rx        = r.rd & ~r.first;
    // Own address compare applies to slave reception only
    assign own_hit   = (r.shreg[7:1] == r.own) & ~r.shreg[0]; // R22
    assign gc_hit    = (r.shreg == 8'h00) & r.gc; // R21
    assign toc_wr    = r.ahb_pend & r.ahb_wr & (r.ahb_a == `OFS_TOC);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = r;
        // Line synchronisers
        n.scl_m = scl_i;
        n.scl_s = r.scl_m;
        n.scl_d = r.scl_s;
        n.sda_m = sda_i;
        n.sda_s = r.sda_m;
        n.sda_d = r.sda_s;
        n.dcnt  = tick ? 8'h00 : r.dcnt + 8'h01;
        if (start_det) begin
            n.busy = 1'b1;
        end else if (stop_det) begin
            n.busy = 1'b0;
        end

        // Bus slave: one wait state, so hrdata comes from a register
        if (r.ahb_pend) begin
            n.ahb_pend = 1'b0;
            n.hready   = 1'b1;
            if (r.ahb_wr) begin
                case (r.ahb_a)
                    `OFS_CTRL: begin
                        n.serial_enable = wd[`B_SERIAL_ENABLE];
                        n.begin_condition_request  = wd[`B_STA]; // R10
                        n.end_condition_request  = wd[`B_STO];
                        n.aa   = wd[`B_AA];
                        if (!wd[`B_SI]) begin
                            n.si = 1'b0; // R18
                        end
                    end
                    `OFS_TOC: begin
                        n.timeout_count_enable = wd[`B_TIMEOUT_COUNT_ENABLE];
                        n.timeout_prescale_select = wd[`B_TIMEOUT_PRESCALE_SELECT];
                        if (!wd[`B_TIF]) begin
                            n.timeout_flag = 1'b0; // R5
                        end
                    end
                    `OFS_ADDR: begin
                        n.own = wd[7:1];
                        n.gc  = wd[0];
                    end
                    `OFS_DATA: n.data = wd;
                    `OFS_IEN: begin
                        n.ea = wd[`B_EA];
                        n.ei = wd[`B_EI];
                    end
                    default: ;
                endcase
            end else begin
                n.hrdata = 32'h0000_0000;
                case (r.ahb_a)
                    `OFS_CTRL: begin
                        n.hrdata[`B_SERIAL_ENABLE] = r.serial_enable;
                        n.hrdata[`B_STA]  = r.begin_condition_request;
                        n.hrdata[`B_STO]  = r.end_condition_request;
                        n.hrdata[`B_SI]   = r.si;
                        n.hrdata[`B_AA]   = r.aa;
                    end
                    `OFS_TOC: begin
                        n.hrdata[`B_TIMEOUT_COUNT_ENABLE] = r.timeout_count_enable;
                        n.hrdata[`B_TIMEOUT_PRESCALE_SELECT] = r.timeout_prescale_select;
                        n.hrdata[`B_TIF]  = r.timeout_flag;
                    end
                    `OFS_ADDR: n.hrdata[7:0] = {r.own, r.gc};
                    `OFS_STAT: n.hrdata[7:0] = r.stat;
                    `OFS_DATA: n.hrdata[7:0] = r.data;
                    `OFS_IEN: begin
                        n.hrdata[`B_EA] = r.ea;
                        n.hrdata[`B_EI] = r.ei;
                    end
                    default: ;
                endcase
            end
        end else if (hsel_i && htrans_i[1] && hready_i) begin
            n.ahb_pend = 1'b1;
            n.ahb_wr   = hwrite_i;
            n.ahb_a    = haddr_i[9:2]; // Word index, one register per aligned word
            n.hready   = 1'b0;
        end

        // Bus engine; hardware sets below win over the writes above
        case (r.eng)
            s_idle: begin
                if (r.begin_condition_request) begin
                    n.eng = r.busy ? s_wait : s_start; // R8
                    n.q   = 2'h0;
                end else if (start_det) begin
                    n.eng   = s_slv;
                    n.bits  = 4'h0;
                    n.first = 1'b1;
                    n.drv   = 1'b0;
                end
            end
            s_wait: begin
                // Another master may still address us while we wait
                if (start_det) begin
                    n.eng   = s_slv; // R10
                    n.bits  = 4'h0;
                    n.first = 1'b1;
                    n.drv   = 1'b0;
                end else if (!r.begin_condition_request) begin
                    n.eng = s_idle; // R24
                end else if (r.busy) begin
                    n.q = 2'h0;
                end else if (adv) begin
                    n.q = r.q + 2'h1;
                    if (r.q == 2'h3) begin
                        n.eng = s_start; // R8
                    end
                end
            end
            s_start: begin
                if (adv) begin
                    n.q = r.q + 2'h1;
                    if (r.q == 2'h3) begin
                        n       = post(n, r.mst ? `ST_RSTART : `ST_START); // R9
                        n.mst   = 1'b1;
                        n.first = 1'b1;
                        n.eng   = s_hold;
                    end
                end
            end
            s_bit: begin
                if (adv) begin
                    n.q = r.q + 2'h1;
                    if (r.q == 2'h2) begin
                        if (r.bits == 4'h8) begin
                            n.ack = ~r.sda_s;
                        end else begin
                            n.shreg = {r.shreg[6:0], r.sda_s};
                        end
                    end
                    if (r.q == 2'h3) begin
                        if (r.bits == 4'h8) begin
                            n.eng   = s_hold;
                            n.first = 1'b0;
                            if (r.first) begin
                                n.rd = r.shreg[0];
                                if (r.shreg[0]) begin
                                    n = post(n, r.ack ? `ST_AR_ACK : `ST_AR_NACK);
                                end else begin
                                    n = post(n, r.ack ? `ST_AW_ACK : `ST_AW_NACK);
                                end
                            end else if (rx) begin
                                n.data = r.shreg;
                                n      = post(n, r.ack ? `ST_RX_ACK : `ST_RX_NACK); // R15
                            end else begin
                                n = post(n, r.ack ? `ST_TX_ACK : `ST_TX_NACK);
                            end
                        end else begin
                            n.bits = r.bits + 4'h1;
                            // Ninth slot: receiver answers per ack assert
                            if (r.bits == 4'h7) begin
                                n.drv = rx & r.aa; // R19 R20
                            end else begin
                                n.drv = ~rx & ~r.shreg[7];
                            end
                        end
                    end
                end
            end
            s_hold: begin
                if (!r.si) begin
                    if (r.mst) begin
                        n.q = 2'h0;
                        if (r.end_condition_request) begin
                            n.eng = s_stop; // R11 R13
                        end else if (r.begin_condition_request) begin
                            n.eng = s_start; // R9
                        end else begin
                            n.eng   = s_bit;
                            n.bits  = 4'h0;
                            n.shreg = r.data;
                            n.drv   = ~rx & ~r.data[7];
                        end
                    end else if (r.end_condition_request) begin
                        // Internal stop only, nothing goes on the bus
                        n.adr = 1'b0; // R12 R14
                        n.end_condition_request = 1'b0;
                        n.eng = s_idle;
                    end else begin
                        n.eng = s_slv;
                    end
                end
            end
            s_stop: begin
                if (adv) begin
                    n.q = r.q + 2'h1;
                    if (r.q == 2'h3) begin
                        n.mst = 1'b0;
                        n.eng = r.begin_condition_request ? s_start : s_idle; // R13
                    end
                end
            end
            s_slv: begin
                if (start_det || stop_det) begin
                    if (r.adr) begin
                        n = post(n, `ST_SSTOP);
                    end
                    n.adr   = 1'b0;
                    n.bits  = 4'h0;
                    n.first = 1'b1;
                    n.drv   = 1'b0;
                    if (stop_det) begin
                        n.eng = s_idle;
                    end
                end else if (scl_rise) begin
                    if (r.bits < 4'h8) begin
                        n.shreg = {r.shreg[6:0], r.sda_s};
                    end
                    n.bits = r.bits + 4'h1;
                end else if (scl_fall && r.bits == 4'h8) begin
                    if (r.first) begin
                        n.drv   = r.aa & (own_hit | gc_hit); // R20 R21
                        n.adr   = n.drv;
                        n.pcode = !n.drv ? `ST_NONE : own_hit ? `ST_SLA : `ST_GCALL;
                    end else if (r.adr) begin
                        n.drv   = r.aa; // R19 R20
                        n.data  = r.shreg;
                        n.pcode = r.aa ? `ST_SRX_ACK : `ST_SRX_NACK;
                    end else begin
                        n.drv   = 1'b0;
                        n.pcode = `ST_NONE;
                    end
                end else if (scl_fall && r.bits == 4'h9) begin
                    n.drv   = 1'b0;
                    n.bits  = 4'h0;
                    n.first = 1'b0;
                    n       = post(n, r.pcode); // R16
                    if (r.pcode == `ST_SRX_NACK) begin
                        n.adr = 1'b0;
                    end
                    if (r.pcode != `ST_NONE) begin
                        n.eng = s_hold;
                    end
                end
            end
            default: n.eng = s_idle;
        endcase
        if (stop_det && r.mst) begin
            n.end_condition_request = 1'b0; // R11
        end

        // Port disabled: engine parked, end request held low
        if (!n.serial_enable) begin
            n.end_condition_request  = 1'b0; // R7
            n.eng  = s_idle;
            n.mst  = 1'b0;
            n.adr  = 1'b0;
            n.busy = 1'b0;
        end
        if (n.eng != r.eng) begin
            n.dcnt = 8'h00;
        end

        // Line drive from the next engine state
        n.scl_oe = n.serial_enable & ((n.eng == s_start & n.q == 2'h3)
                 | (n.eng == s_bit & n.q == 2'h0) | (n.eng == s_stop & n.q == 2'h0)
                 | (n.eng == s_hold)); // R17 R18
        n.sda_oe = n.serial_enable & ((n.eng == s_start & n.q[1])
                 | (n.eng == s_stop & n.q != 2'h3)
                 | ((n.eng == s_bit | n.eng == s_slv) & n.drv));

        // Time-out: overflow first, so a simultaneous flag rise still zeroes it
        if (run && pre_hit) begin
            n.tcnt = r.tcnt + 14'h0001; // R1 R3
            if (r.tcnt == `TO_MAX) begin
                n.timeout_flag = 1'b1; // R4 R23
            end
        end
        if (run) begin
            n.pre = r.pre + 2'h1;
        end
        if (n.si && !r.si) begin
            n.tcnt = 14'h0000; // R2
            n.pre  = 2'h0;
        end
        n.irq = n.ea & n.ei & (n.si | n.timeout_flag); // R4 R15 R18
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            r        <= '0;
            r.eng    <= s_idle;
            r.hready <= 1'b1;
            r.stat   <= `ST_NONE;
            r.pcode  <= `ST_NONE;
        end else begin
            r <= n;
        end
    end

    // Outputs; lines are only ever pulled low
    assign hrdata_o    = r.hrdata;
    assign hreadyout_o = r.hready;
    assign hresp_o     = 1'b0;
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_o    = r.scl_oe;
    assign sda_oe_o    = r.sda_oe;
    assign irq_o       = r.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence stop_done;
        r.eng == s_stop && r.q == 2'h3 && adv;
    endsequence
    sequence rx_ack_slot;
        r.eng == s_bit && r.bits == 4'h8 && rx && r.q == 2'h0;
    endsequence

    a_to_wrap: assert property ( // R23
        run && pre_hit && r.tcnt == `TO_MAX |=> r.timeout_flag && r.tcnt == 14'h0000)
        else $error("time-out overflow missed");
    a_to_idle: assert property ( // R1
        !(r.timeout_count_enable && r.serial_enable) ##1 !$rose(r.si) |-> $stable(r.tcnt))
        else $error("time-out counted while disabled");
    a_to_clear: assert property ($rose(r.si) |-> r.tcnt == 14'h0000) // R2
        else $error("time-out not cleared on flag");
    a_to_timeout_prescale_select: assert property ( // R3
        run && r.timeout_prescale_select && r.pre != `PRE_LAST |=> $stable(r.tcnt) || $rose(r.si))
        else $error("prescaled count advanced early");
    a_tif_sticky: assert property ( // R5
        r.timeout_flag && !(toc_wr && !wd[`B_TIF]) |=> r.timeout_flag)
        else $error("time-out flag lost");
    a_float_off: assert property (!r.serial_enable |-> !r.scl_oe && !r.sda_oe && !r.end_condition_request) // R7
        else $error("lines driven while disabled");
    a_no_f8: assert property ($rose(r.si) |-> r.stat != `ST_NONE) // R16
        else $error("flag set with no-information code");
    a_scl_stretch: assert property (r.si && r.eng == s_hold |-> r.scl_oe) // R17
        else $error("clock not stretched");
    a_si_release: assert property ($fell(r.si) && r.serial_enable |=> r.eng != s_hold) // R18
        else $error("stretch kept after flag clear");
    a_irq_drop: assert property ($fell(r.si) && !r.timeout_flag |-> !r.irq) // R18
        else $error("request kept after flag clear");
    a_no_start: assert property (!r.begin_condition_request && r.eng != s_start |=> r.eng != s_start) // R24
        else $error("start without request");
    a_stop_start: assert property (stop_done ##0 r.begin_condition_request |=> r.eng == s_start) // R13
        else $error("no start after stop");
    a_rx_ack: assert property (rx_ack_slot |-> r.sda_oe == r.aa) // R19
        else $error("wrong master receiver answer");

endmodule

// File: verif/i2c_peer.sv
// Bus peer: a receive-only slave on the two open-drain lines.
// Assumes the testbench resolves the wires; the peer only pulls sda low.
`timescale 1ns/1ps
module i2c_peer (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [6:0] addr_i,
    output logic            sda_oe_o
);
    logic [3:0] cnt = 4'hf;
    logic [7:0] sh  = 8'h00;
    // --------------------------------
    // Frame tracking
    // --------------------------------
    // Start or repeated start restarts the bit count
    always @(negedge sda_i) if (scl_i) cnt = 4'h0;
    always @(posedge scl_i) begin
        if (cnt < 4'h8) sh = {sh[6:0], sda_i};
        if (cnt < 4'hf) cnt = cnt + 4'h1;
    end
    // Ack slot only on own address, released at the next low phase
    always @(negedge scl_i) sda_oe_o <= (cnt == 4'h8) && (sh[7:1] == addr_i);
    initial sda_oe_o = 1'b0;
endmodule

// File: verif/tb_i2c_control_and_timeout.sv
// Self-checking bench: registers over AHB-Lite, time-out counter, two master frames.
// Assumes the design answers each transfer by its own hreadyout.
`timescale 1ns/1ps
`include "i2c_ctl_cfg.svh"
module tb_i2c_control_and_timeout;
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic        hready, hresp, scl_oe, sda_oe, peer_oe, irq, scl_w, sda_w;
    logic [6:0]  paddr;
    int          err_total = 0, check_count = 0;
    // --------------------------------
    // Wires pulled high unless someone pulls low
    // --------------------------------
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | peer_oe);
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    i2c_ctl #(.QTR_CYC(4)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w),
        .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq));
    i2c_peer peer_u (.scl_i(scl_w), .sda_i(sda_w), .addr_i(paddr), .sda_oe_o(peer_oe));
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk_i);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {22'h0, a, 2'b00}; hwrite <= wr;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        htrans <= 2'b00; hwdata <= wd;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_ev();
        for (int i = 0; i < 500; i++) begin
            bus(1'b0, `OFS_CTRL, 0);
            if (rd[`B_SI] === 1'b1) break;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, well beyond the ~35k cycles of the sequence
    initial begin
        #(25 * 60000);
        err_total++;
        end_sim();
    end
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        void'($urandom(32'h25c0));
        paddr = 7'($urandom);
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        bus(1'b0, `OFS_STAT, 0); chk("reset state", rd, 32'hf8);
        bus(1'b0, `OFS_CTRL, 0); chk("reset ctrl", rd, 0);
        bus(1'b0, 8'hfc, 0); chk("unmapped", rd, 0);
        chk("hresp", hresp, 0);
        $display("test reset done");
        bus(1'b1, `OFS_IEN, 3);
        bus(1'b1, `OFS_ADDR, {24'h0, paddr, 1'b0});
        bus(1'b0, `OFS_ADDR, 0); chk("own address", rd, {24'h0, paddr, 1'b0});
        bus(1'b1, `OFS_CTRL, 32'h40);
        bus(1'b1, `OFS_TOC, 32'h04);
        repeat (16400) @(posedge sys_clk_i);
        bus(1'b0, `OFS_TOC, 0); chk("overflow flag", rd, 32'h05);
        chk("timeout irq", irq, 1);
        repeat (100) @(posedge sys_clk_i);
        bus(1'b0, `OFS_TOC, 0); chk("flag kept", rd, 32'h05);
        bus(1'b1, `OFS_TOC, 32'h06);
        bus(1'b0, `OFS_TOC, 0); chk("flag cleared", rd, 32'h06);
        repeat (16400) @(posedge sys_clk_i);
        bus(1'b0, `OFS_TOC, 0); chk("timeout_prescale_select no wrap", rd, 32'h06);
        bus(1'b1, `OFS_TOC, 0);
        $display("test timeout done");
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `OFS_CTRL, 32'h60);
            wait_ev();
            bus(1'b0, `OFS_STAT, 0); chk("start code", rd, `ST_START);
            chk("event irq", irq, 1);
            chk("scl stretched", scl_w, 0);
            bus(1'b1, `OFS_DATA, {24'h0, paddr + 7'(i), 1'b0});
            bus(1'b1, `OFS_CTRL, 32'h40);
            wait_ev();
            bus(1'b0, `OFS_STAT, 0);
            chk("addr ack", rd, (i == 0) ? `ST_AW_ACK : `ST_AW_NACK);
            bus(1'b1, `OFS_CTRL, 32'h50);
            // Always read at least once; rd still holds the state code here
            for (int k = 0; k < 200; k++) begin
                bus(1'b0, `OFS_CTRL, 0);
                if (rd[`B_STO] === 1'b0) break;
            end
            chk("stop done", rd[`B_STO], 0);
            chk("irq withdrawn", irq, 0);
        end
        $display("test master done");
        bus(1'b1, `OFS_CTRL, 32'h14);
        bus(1'b0, `OFS_CTRL, 0); chk("disabled ctrl", rd, 32'h04);
        chk("lines float", {scl_oe, sda_oe}, 0);
        $display("test disable done");
        end_sim();
    end
endmodule
